/* common/move_exec_pkg.sv */
// Constants, opcodes and decode for the move execution unit
package move_exec_pkg;
    // Register byte offsets
    localparam logic [7:0] REG_INSTR  = 8'h00;
    localparam logic [7:0] REG_ACC    = 8'h04;
    localparam logic [7:0] REG_BANK   = 8'h08;
    localparam logic [7:0] REG_PAGE   = 8'h0c;
    localparam logic [7:0] REG_OPTION = 8'h10;
    localparam logic [7:0] REG_PTR0   = 8'h14;
    localparam logic [7:0] REG_PTR1   = 8'h18;
    localparam logic [7:0] REG_STATUS = 8'h1c;
    localparam logic [7:0] REG_PC     = 8'h20;
    localparam logic [7:0] REG_MADDR  = 8'h24;
    localparam logic [7:0] REG_MDATA  = 8'h28;
    localparam logic [7:0] REG_EA     = 8'h2c;
    localparam logic [7:0] REG_LAST   = 8'h2c;
    // Reset values
    localparam logic [7:0]  RST_ACC    = 8'h00;
    localparam logic [4:0]  RST_BANK   = 5'h00;
    localparam logic [6:0]  RST_PAGE   = 7'h00;
    localparam logic [7:0]  RST_OPTION = 8'hff;
    localparam logic [15:0] RST_PTR    = 16'h0000;
    localparam logic [7:0]  RST_STATUS = 8'h00;
    localparam logic [14:0] RST_PC     = 15'h0000;
    localparam logic [13:0] RST_INSTR  = 14'h0000;
    localparam logic [7:0]  RST_MADDR  = 8'h00;
    localparam logic [15:0] RST_EA     = 16'h0000;
    // Whole-word opcodes, and patterns on the upper instruction bits
    localparam logic [13:0] OPC_IDLE   = 14'h0000;
    localparam logic [13:0] OPC_OPTION = 14'h0062;
    localparam logic [8:0]  PAT_BANK   = 9'h001;
    localparam logic [6:0]  PAT_PAGE   = 7'h63;
    localparam logic [5:0]  PAT_ACCLIT = 6'h30;
    localparam logic [6:0]  PAT_STFILE = 7'h01;
    localparam logic [10:0] PAT_STIND  = 11'h003;
    localparam logic [6:0]  PAT_STREL  = 7'h7f;
    // Field positions
    localparam int unsigned IND_SEL_POS = 2;
    localparam int unsigned REL_SEL_POS = 6;
    localparam int unsigned PROG_BIT    = 15;
    localparam logic [5:0]  FILE_IND    = 6'h00;
    // Bus answers
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [3:0] {
        OP_IDLE, OP_BANK, OP_PAGE, OP_ACCLIT, OP_STFILE,
        OP_STIND, OP_STREL, OP_OPTION, OP_BAD
    } op_t;

    function automatic op_t decode_op(input logic [13:0] i);
        if (i == OPC_IDLE)            return OP_IDLE;
        else if (i == OPC_OPTION)     return OP_OPTION;
        else if (i[13:5] == PAT_BANK) return OP_BANK;
        else if (i[13:7] == PAT_PAGE) return OP_PAGE;
        else if (i[13:8] == PAT_ACCLIT) return OP_ACCLIT;
        else if (i[13:7] == PAT_STFILE) return OP_STFILE;
        else if (i[13:3] == PAT_STIND) return OP_STIND;
        else if (i[13:7] == PAT_STREL) return OP_STREL;
        else                          return OP_BAD;
    endfunction
endpackage

/* rtl/data_ram.sv */
// Data memory, 256 bytes, registered read port
`timescale 1ns/1ps
module data_ram (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       we,
    input  wire logic [7:0] waddr,
    input  wire logic [7:0] wdata,
    input  wire logic [7:0] raddr,
    output logic      [7:0] rdata
);
    logic [7:0] mem [0:255];
    logic [7:0] rdata_q;

    always_ff @(posedge aclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Content is undefined until written; only the read register resets
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= mem[raddr];
        end
    end

    assign rdata = rdata_q;
endmodule // data_ram

/* rtl/move_exec.sv */
// Literal and indirect move execution unit with AXI4-Lite access
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// How it works
// RULE1: Bank load puts its 5-bit immediate in bank select, flags untouched.
// RULE2: Page latch load puts its 7-bit immediate in program counter high latch.
// RULE3: Accumulator literal load puts 8-bit immediate in accumulator, one cycle.
// RULE4: File store copies accumulator to file register selected by 7-bit address.
// RULE5: Indirect store writes accumulator at pointer plus/minus one, offset, or itself.
// RULE6: Update code 00 pre-inc, 01 pre-dec, 10 post-inc, 11 post-dec.
// RULE7: Relative form stores at pointer plus signed 6-bit offset; pointer kept.
// RULE8: Pointers are 16 bits and wrap modulo 65536 on increment or decrement.
// RULE9: Pointer updates never touch the status flags.
// RULE10: Indirect data port addresses hold nothing; access goes through pointer.
// RULE11: Option load copies accumulator into option register, flags untouched.
// RULE12: Idle instruction only advances program counter, one cycle.
// RULE13: Pointer is a full 16-bit address spanning program and data space.
module move_exec (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready
);
    ////////////////////////////////////////////////////////////////////////////
    logic [7:0]               aw_addr_q;
    logic                     aw_have_q;
    logic [31:0]              w_data_q;
    logic [3:0]               w_strb_q;
    logic                     w_have_q;
    logic                     bvalid_q;
    logic [1:0]               bresp_q;
    logic                     rvalid_q;
    logic [31:0]              rdata_q;
    logic [1:0]               rresp_q;
    logic                     wr_go;
    logic [31:0]              regv [0:15];
    logic [31:0]              wr_val;
    logic [7:0]               acc_q;
    logic [4:0]               bank_select_register_q;
    logic [6:0]               program_counter_high_latch_q;
    logic [7:0]               option_q;
    logic [15:0]              ptr0_q;
    logic [15:0]              ptr1_q;
    logic [7:0]               status_q;
    logic [14:0]              pc_q;
    logic [13:0]              instr_q;
    logic [7:0]               mem_addr_q;
    logic [15:0]              last_ea_q;
    logic                     drop_q;
    logic [7:0]               mem_rdata;
    logic                     exec_go;
    logic [13:0]              instr;
    move_exec_pkg::op_t       op;
    logic                     sel_n;
    logic [15:0]              ptr;
    logic [15:0]              ptr_inc;
    logic [15:0]              ptr_dec;
    logic [15:0]              ofs;
    logic [15:0]              ea;
    logic [15:0]              ptr_new;
    logic                     ptr_upd;
    logic                     store;
    logic                     mem_we;
    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write side: address and data taken in either order
    assign awready = !aw_have_q;
    assign wready  = !w_have_q;
    assign bvalid  = bvalid_q;
    assign bresp   = bresp_q;
    assign wr_go   = aw_have_q && w_have_q && !bvalid_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            aw_addr_q <= 8'h00;
        end else if (awvalid && awready) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= awaddr;
        end else if (wr_go) begin
            aw_have_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_have_q <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end else if (wvalid && wready) begin
            w_have_q <= 1'b1;
            w_data_q <= wdata;
            w_strb_q <= wstrb;
        end else if (wr_go) begin
            w_have_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= move_exec_pkg::RESP_OKAY;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q  <= (aw_addr_q <= move_exec_pkg::REG_LAST && aw_addr_q[1:0] == 2'b00)
                        ? move_exec_pkg::RESP_OKAY : move_exec_pkg::RESP_SLVERR;
        end else if (bready) begin
            bvalid_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register view, indexed by word; unmapped words read zero
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            regv[i] = 32'h0000_0000;
        end
        regv[move_exec_pkg::REG_INSTR[5:2]]  = {18'h00000, instr_q};
        regv[move_exec_pkg::REG_ACC[5:2]]    = {24'h000000, acc_q};
        regv[move_exec_pkg::REG_BANK[5:2]]   = {27'h0000000, bank_select_register_q};
        regv[move_exec_pkg::REG_PAGE[5:2]]   = {25'h0000000, program_counter_high_latch_q};
        regv[move_exec_pkg::REG_OPTION[5:2]] = {24'h000000, option_q};
        regv[move_exec_pkg::REG_PTR0[5:2]]   = {16'h0000, ptr0_q};
        regv[move_exec_pkg::REG_PTR1[5:2]]   = {16'h0000, ptr1_q};
        regv[move_exec_pkg::REG_STATUS[5:2]] = {24'h000000, status_q};
        regv[move_exec_pkg::REG_PC[5:2]]     = {17'h00000, pc_q};
        regv[move_exec_pkg::REG_MADDR[5:2]]  = {24'h000000, mem_addr_q};
        regv[move_exec_pkg::REG_MDATA[5:2]]  = {24'h000000, mem_rdata};
        regv[move_exec_pkg::REG_EA[5:2]]     = {15'h0000, drop_q, last_ea_q};
    end
    // Byte strobes merge into the current register value
    always_comb begin
        wr_val = regv[aw_addr_q[5:2]];
        for (int i = 0; i < 4; i++) begin
            if (w_strb_q[i]) begin
                wr_val[8*i+:8] = w_data_q[8*i+:8];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read side, one answer at a time
    assign arready = !rvalid_q;
    assign rvalid  = rvalid_q;
    assign rdata   = rdata_q;
    assign rresp   = rresp_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= move_exec_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid_q <= 1'b1;
            if (araddr <= move_exec_pkg::REG_LAST && araddr[1:0] == 2'b00) begin
                rdata_q <= regv[araddr[5:2]];
                rresp_q <= move_exec_pkg::RESP_OKAY;
            end else begin
                rdata_q <= 32'h0000_0000;
                rresp_q <= move_exec_pkg::RESP_SLVERR;
            end
        end else if (rready) begin
            rvalid_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Instruction decode and address generation
    assign exec_go = wr_go && aw_addr_q == move_exec_pkg::REG_INSTR;
    assign instr   = w_data_q[13:0];
    assign op      = move_exec_pkg::decode_op(instr);
    always_comb begin
        unique case (op)
            move_exec_pkg::OP_STREL:  sel_n = instr[move_exec_pkg::REL_SEL_POS];
            move_exec_pkg::OP_STFILE: sel_n = instr[0];
            default:                  sel_n = instr[move_exec_pkg::IND_SEL_POS];
        endcase
    end
    assign ptr     = sel_n ? ptr1_q : ptr0_q;
    assign ptr_inc = ptr + 16'h0001; // RULE8
    assign ptr_dec = ptr - 16'h0001; // RULE8
    assign ofs     = {{10{instr[5]}}, instr[5:0]};
    always_comb begin
        ea      = ptr;
        ptr_new = ptr;
        ptr_upd = 1'b0;
        store   = 1'b0;
        unique case (op)
            move_exec_pkg::OP_STIND: begin
                store   = 1'b1; // RULE5
                ptr_upd = 1'b1;
                ptr_new = instr[0] ? ptr_dec : ptr_inc; // RULE6
                ea      = instr[1] ? ptr : ptr_new; // RULE6
            end
            move_exec_pkg::OP_STREL: begin
                store = 1'b1;
                ea    = ptr + ofs; // RULE7
            end
            move_exec_pkg::OP_STFILE: begin
                store = 1'b1; // RULE4
                // Port addresses have no storage and go through the pointer
                if (instr[6:1] != move_exec_pkg::FILE_IND) begin // RULE10
                    ea = {8'h00, bank_select_register_q[0], instr[6:0]};
                end
            end
            default: ;
        endcase
    end
    // Program space is read-only here, so stores there are dropped
    assign mem_we = exec_go && store && !ea[move_exec_pkg::PROG_BIT]; // RULE13
    data_ram u_ram (
        .aclk    (aclk),
        .aresetn (aresetn),
        .we      (mem_we),
        .waddr   (ea[7:0]),
        .wdata   (acc_q),
        .raddr   (mem_addr_q),
        .rdata   (mem_rdata)
    );
    ////////////////////////////////////////////////////////////////////////////
    // Core registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc_q <= move_exec_pkg::RST_ACC;
        end else if (wr_go && aw_addr_q == move_exec_pkg::REG_ACC) begin
            acc_q <= wr_val[7:0];
        end else if (exec_go && op == move_exec_pkg::OP_ACCLIT) begin
            acc_q <= instr[7:0]; // RULE3
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bank_select_register_q <= move_exec_pkg::RST_BANK;
        end else if (wr_go && aw_addr_q == move_exec_pkg::REG_BANK) begin
            bank_select_register_q <= wr_val[4:0];
        end else if (exec_go && op == move_exec_pkg::OP_BANK) begin
            bank_select_register_q <= instr[4:0]; // RULE1
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            program_counter_high_latch_q <= move_exec_pkg::RST_PAGE;
        end else if (wr_go && aw_addr_q == move_exec_pkg::REG_PAGE) begin
            program_counter_high_latch_q <= wr_val[6:0];
        end else if (exec_go && op == move_exec_pkg::OP_PAGE) begin
            program_counter_high_latch_q <= instr[6:0]; // RULE2
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            option_q <= move_exec_pkg::RST_OPTION;
        end else if (wr_go && aw_addr_q == move_exec_pkg::REG_OPTION) begin
            option_q <= wr_val[7:0];
        end else if (exec_go && op == move_exec_pkg::OP_OPTION) begin
            option_q <= acc_q; // RULE11
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ptr0_q <= move_exec_pkg::RST_PTR;
            ptr1_q <= move_exec_pkg::RST_PTR;
        end else if (wr_go && aw_addr_q == move_exec_pkg::REG_PTR0) begin
            ptr0_q <= wr_val[15:0];
        end else if (wr_go && aw_addr_q == move_exec_pkg::REG_PTR1) begin
            ptr1_q <= wr_val[15:0];
        end else if (exec_go && ptr_upd && !sel_n) begin
            ptr0_q <= ptr_new; // RULE6
        end else if (exec_go && ptr_upd && sel_n) begin
            ptr1_q <= ptr_new; // RULE6
        end
    end
    // Flags change only by software; no move instruction writes them
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_q <= move_exec_pkg::RST_STATUS;
        end else if (wr_go && aw_addr_q == move_exec_pkg::REG_STATUS) begin
            status_q <= wr_val[7:0]; // RULE9
        end
    end
    // Unknown opcodes are ignored and do not advance the counter
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pc_q    <= move_exec_pkg::RST_PC;
            instr_q <= move_exec_pkg::RST_INSTR;
        end else if (exec_go) begin
            instr_q <= instr;
            if (op != move_exec_pkg::OP_BAD) begin
                pc_q <= pc_q + 15'h0001; // RULE12
            end
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            last_ea_q <= move_exec_pkg::RST_EA;
            drop_q    <= 1'b0;
        end else if (exec_go && store) begin
            last_ea_q <= ea;
            drop_q    <= ea[move_exec_pkg::PROG_BIT]; // RULE13
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mem_addr_q <= move_exec_pkg::RST_MADDR;
        end else if (wr_go && aw_addr_q == move_exec_pkg::REG_MADDR) begin
            mem_addr_q <= wr_val[7:0];
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_BANK: assert property (exec_go && op == move_exec_pkg::OP_BANK |=> // RULE1
        bank_select_register_q == $past(instr[4:0]) && $stable(status_q))
        else $error("bank load wrong");
    AST_PAGE: assert property (exec_go && op == move_exec_pkg::OP_PAGE |=> // RULE2
        program_counter_high_latch_q == $past(instr[6:0]))
        else $error("page latch load wrong");
    AST_ACCLIT: assert property (exec_go && op == move_exec_pkg::OP_ACCLIT |=> // RULE3
        acc_q == $past(instr[7:0]) && pc_q == 15'($past(pc_q) + 15'h0001))
        else $error("accumulator literal wrong");
    AST_FILE: assert property (exec_go && op == move_exec_pkg::OP_STFILE // RULE4
        && instr[6:1] != 6'h00 |-> mem_we && ea[7:0] == {bank_select_register_q[0], instr[6:0]})
        else $error("file store wrong");
    AST_PORT: assert property (exec_go && op == move_exec_pkg::OP_STFILE // RULE10
        && instr[6:1] == 6'h00 |=> last_ea_q == (instr[0] ? ptr1_q : ptr0_q))
        else $error("port not redirected");
    AST_PRE: assert property (exec_go && op == move_exec_pkg::OP_STIND && !instr[1] // RULE5
        |=> last_ea_q == ($past(instr[2]) ? ptr1_q : ptr0_q))
        else $error("pre-update address wrong");
    AST_POST: assert property (exec_go && op == move_exec_pkg::OP_STIND && instr[1] // RULE6
        |=> last_ea_q == $past(ptr) && last_ea_q != ($past(instr[2]) ? ptr1_q : ptr0_q))
        else $error("post-update address wrong");
    AST_STEP: assert property (exec_go && op == move_exec_pkg::OP_STIND && !instr[2] // RULE8
        |=> 16'(ptr0_q - $past(ptr0_q)) == ($past(instr[0]) ? 16'hffff : 16'h0001))
        else $error("pointer step wrong");
    AST_REL: assert property (exec_go && op == move_exec_pkg::OP_STREL |=> // RULE7
        $stable(ptr0_q) && $stable(ptr1_q) && last_ea_q == 16'($past(ptr) + $past(ofs)))
        else $error("relative store wrong");
    AST_FLAGS: assert property ($changed(status_q) |-> // RULE9
        $past(wr_go && aw_addr_q == move_exec_pkg::REG_STATUS))
        else $error("status changed by instruction");
    AST_OPTION: assert property (exec_go && op == move_exec_pkg::OP_OPTION |=> // RULE11
        option_q == $past(acc_q))
        else $error("option load wrong");
    AST_IDLE: assert property (exec_go && op == move_exec_pkg::OP_IDLE |=> // RULE12
        $stable(acc_q) && $stable(ptr0_q) && $stable(ptr1_q) && $stable(option_q)
        && pc_q == 15'($past(pc_q) + 15'h0001))
        else $error("idle changed state");
    AST_SPACE: assert property (exec_go && store |-> // RULE13
        mem_we == !ea[15] ##1 drop_q == $past(ea[15]))
        else $error("space select wrong");

    COV_IND: cover property (exec_go && op == move_exec_pkg::OP_STIND);
    COV_WRAP: cover property (exec_go && op == move_exec_pkg::OP_STIND && ptr == 16'hffff);
    COV_NEG: cover property (exec_go && op == move_exec_pkg::OP_STREL && instr[5]);
    COV_DROP: cover property (exec_go && store && ea[15]);
endmodule // move_exec

/* dv/tb_top.sv */
// Self-checking bench for the move execution unit
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module tb_top;
    logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
    logic        bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, lfsr = 32'h19a9537d;
    logic [3:0]  wstrb = 4'h0, strb = 4'hf;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    int          fails = 0, tests_run = 0, acc, bank, page, opt, stat, pc, ea;
    int          ptr[2];
    int          mem[256];

    always #5 aclk = ~aclk;

    move_exec dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction

    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // Sample handshakes mid-cycle so the edge's own updates never race the bench
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ta, tw, tb;
        int   n;
        n = 0;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= strb;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(negedge aclk);
            ta = awvalid & awready;
            tw = wvalid & wready;
            tb = bvalid;
            r  = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            n++;
        end while (!tb && n < 50);
        bready <= 1'b0;
        if (!tb) fails++;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, tr;
        int   n;
        n = 0;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(negedge aclk);
            ta = arvalid & arready;
            tr = rvalid;
            d  = rdata;
            r  = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
            n++;
        end while (!tr && n < 50);
        rready <= 1'b0;
        if (!tr) fails++;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        chk(d, e);
        chk({30'h0, r}, {30'h0, move_exec_pkg::RESP_OKAY});
    endtask

    task automatic wrc(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        wr(a, d, r);
        chk({30'h0, r}, {30'h0, move_exec_pkg::RESP_OKAY});
    endtask

    task automatic chkall();
        rdc(move_exec_pkg::REG_ACC, acc);
        rdc(move_exec_pkg::REG_BANK, bank);
        rdc(move_exec_pkg::REG_PAGE, page);
        rdc(move_exec_pkg::REG_OPTION, opt);
        rdc(move_exec_pkg::REG_PTR0, ptr[0]);
        rdc(move_exec_pkg::REG_PTR1, ptr[1]);
        rdc(move_exec_pkg::REG_STATUS, stat);
        rdc(move_exec_pkg::REG_PC, pc);
    endtask

    task automatic setp(input int n, input int v);
        ptr[n] = v & 65535;
        wrc(n ? move_exec_pkg::REG_PTR1 : move_exec_pkg::REG_PTR0, ptr[n]);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Kind 8 is an undefined word: ignored, counter held
    task automatic exec(input int k, input logic [31:0] v);
        logic [13:0] i;
        int          a;
        ea = -1;
        a  = ptr[v[2]];
        case (k)
            0: i = move_exec_pkg::OPC_IDLE;
            1: begin i = {move_exec_pkg::PAT_BANK, v[4:0]}; bank = v[4:0]; end
            2: begin i = {move_exec_pkg::PAT_PAGE, v[6:0]}; page = v[6:0]; end
            3: begin i = {move_exec_pkg::PAT_ACCLIT, v[7:0]}; acc = v[7:0]; end
            4: begin
                i  = {move_exec_pkg::PAT_STFILE, v[6:0]};
                ea = (v[6:1] == 0) ? ptr[v[0]] : (bank & 1) * 128 + v[6:0];
            end
            5: begin
                i  = {move_exec_pkg::PAT_STIND, v[2:0]};
                ptr[v[2]] = (a + (v[1:0] == 0 || v[1:0] == 2 ? 1 : -1)) & 65535;
                ea = v[1] ? a : ptr[v[2]];
            end
            6: begin
                i  = {move_exec_pkg::PAT_STREL, v[6:0]};
                ea = (ptr[v[6]] + $signed(v[5:0])) & 65535;
            end
            7: begin i = move_exec_pkg::OPC_OPTION; opt = acc; end
            default: i = 14'h2000;
        endcase
        if (k < 8) pc = (pc + 1) & 32767;
        wrc(move_exec_pkg::REG_INSTR, {18'h0, i});
        rdc(move_exec_pkg::REG_INSTR, {18'h0, i});
        if (ea >= 0 && ea < 32768) begin
            mem[ea & 255] = acc;
            wrc(move_exec_pkg::REG_MADDR, ea & 255);
            rdc(move_exec_pkg::REG_MDATA, mem[ea & 255]);
        end
        if (k == 5 || k == 6) rdc(move_exec_pkg::REG_EA, ((ea >> 15) << 16) | ea);
        chkall();
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        {acc, bank, page, stat, pc, ptr[0], ptr[1]} = '0;
        opt = move_exec_pkg::RST_OPTION;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        chkall();
        wr(8'h30, 32'h1, r);
        chk({30'h0, r}, {30'h0, move_exec_pkg::RESP_SLVERR});
        rd(8'h30, d, r);
        chk({r, d[29:0]}, {move_exec_pkg::RESP_SLVERR, 30'h0});
        stat = 8'ha5;
        wrc(move_exec_pkg::REG_STATUS, stat);
        // Single byte lane must merge into the held pointer value
        setp(0, 16'h12cd);
        strb = 4'h2;
        wrc(move_exec_pkg::REG_PTR0, 32'hffff_ab56);
        strb = 4'hf;
        ptr[0] = 16'habcd;
        wrc(move_exec_pkg::REG_PC, 32'h7fff);
        chkall();
        for (int k = 0; k < 9; k++) exec(k, rnd());
        setp(0, 16'hffff);
        exec(5, 32'h0);
        setp(1, 16'h0000);
        exec(5, 32'h5);
        exec(6, 32'h60);
        exec(6, 32'h1f);
        exec(4, 32'h0);
        for (int m = 0; m < 4; m++) exec(5, m | 32'h4);
        repeat (150) begin
            if (rnd() % 5 == 0) setp(lfsr[7], lfsr[8] ? lfsr[31:16] : lfsr[23:16]);
            exec(rnd() % 9, rnd());
        end
        finish_test();
    end

    initial begin
        #(60000 * 10);
        fails++;
        finish_test();
    end
endmodule // tb_top
